/* File: rtl/cpsb_core.sv */
/*
 * Code-protection security bits of the on-chip program flash: the
 * security register reached over APB in programming mode, the read lock,
 * the table-read restriction, port 0 encoding and oscillator gain control.
 * Assumes prog_mode_i is an asynchronous pin; all other inputs are on
 * sys_clk_i. pready is always high; every answer comes in the first access cycle.
 */
// Contract
// - Security register is reachable only while in flash programming mode.
// - A bit programmed to zero cannot be raised by later programming.
// - Only a full erase returns cleared bits to one; the code also reloads SEC_RST_VAL, 8'hFF, on reset.
// - Security register sits at top address of the loader flash bank.
// - Lock bit zero refuses external access to flash and security register.
// - Restrict bit zero: table reads from external code reach only external memory.
// - Table reads run from internal code reach internal and external memory.
// - Restrict bit one: table reads are not restricted at all.
// - Encryption bit enables encoding of every port 0 output value.
// - Encryption bit is disabled again only by a whole-chip erase; the code also disables it on reset.
// - Bit seven at zero halves the oscillator amplifier gain.
`timescale 1ns/1ps
module cpsb_core
   import cpsb_pkg::*;
#(
   parameter logic [7:0] ENC_KEY = 8'h5A    // Arbitrary scrambling key
) (
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              rst_b_i,
   // APB slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [APB_AW-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   input  wire logic [3:0]        pstrb_i,
   output      logic [31:0]       prdata_o,
   output      logic              pready_o,
   output      logic              pslverr_o,
   // Programming mode pin
   input  wire logic              prog_mode_i,
   // Table-read request from the core
   input  wire logic              tbl_rd_i,
   input  wire logic              tbl_from_ext_i,
   input  wire logic              tbl_tgt_int_i,
   output      logic              tbl_rd_int_o,
   output      logic              tbl_rd_ext_o,
   // Port 0 bus
   input  wire logic [7:0]        p0_data_i,
   output      logic [7:0]        p0_data_o,
   // Protection outputs
   output      logic              ext_access_ok_o,
   output      logic              osc_gain_half_o
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic        prog_s1;
      logic        prog_s2;
      logic [16:0] target;
      logic [7:0]  sec;
      logic [31:0] rdata;
      logic        err;
   } cpsb_state_t;

   cpsb_state_t st;
   cpsb_state_t next_st;
   cpsb_sec_if  sec_if ();

   logic      setup;
   logic      access;
   logic      prog_mode;
   logic      lock_open;
   logic      at_sec_loc;
   logic      erase_evt;
   logic      prog_evt;
   cpsb_sel_t sel;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic cpsb_sel_t cpsb_decode(input logic [APB_AW-1:0] a);
      case (a)
         OFS_TARGET:  cpsb_decode = CPSB_SEL_TARGET;
         OFS_DATA:    cpsb_decode = CPSB_SEL_DATA;
         OFS_COMMAND: cpsb_decode = CPSB_SEL_COMMAND;
         OFS_STATUS:  cpsb_decode = CPSB_SEL_STATUS;
         default:     cpsb_decode = CPSB_SEL_NONE;
      endcase
   endfunction

   // Expands byte strobes to a bit mask
   function automatic logic [31:0] cpsb_lanes(input logic [3:0] s);
      logic [31:0] m;
      m = 32'h00000000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{s[i]}};
      end
      return m;
   endfunction

   assign sel        = cpsb_decode(paddr_i);
   assign setup      = psel_i & ~penable_i;
   assign access     = psel_i & penable_i;
   assign prog_mode  = st.prog_s2;
   assign lock_open  = st.sec[LOCK_POS];
   assign at_sec_loc = (st.target[BANK_POS] == BANK_LOADER) &&
                       (st.target[15:0] == SEC_LOC_ADDR);
   assign erase_evt  = access & ~st.err & pwrite_i & (sel == CPSB_SEL_COMMAND) &
                       pstrb_i[0] & pwdata_i[CMD_ERASE_POS];
   assign prog_evt   = access & ~st.err & pwrite_i & (sel == CPSB_SEL_DATA) & pstrb_i[0];

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [31:0] wmask;
      wmask   = cpsb_lanes(pstrb_i);
      next_st = st;
      next_st.prog_s1 = prog_mode_i;
      next_st.prog_s2 = st.prog_s1;
      // Setup cycle: decide refusal and capture read data
      if (setup) begin
         next_st.rdata = 32'h00000000;
         next_st.err   = 1'b0;
         case (sel)
            CPSB_SEL_TARGET: begin
               next_st.rdata[16:0] = st.target;
            end
            CPSB_SEL_DATA: begin
               if (!prog_mode || !lock_open || !at_sec_loc) begin
                  next_st.err = 1'b1;
               end else if (!pwrite_i) begin
                  next_st.rdata[7:0] = st.sec;
               end
            end
            CPSB_SEL_COMMAND: begin
               next_st.err = ~prog_mode;
            end
            CPSB_SEL_STATUS: begin
               next_st.err = pwrite_i;
               next_st.rdata[STAT_PROG_POS]  = prog_mode;
               next_st.rdata[STAT_EXTOK_POS] = ext_access_ok_o;
               next_st.rdata[STAT_TRR_POS]   = ~st.sec[TRR_POS];
               next_st.rdata[STAT_ENC_POS]   = ~st.sec[ENC_POS];
               next_st.rdata[STAT_OSC_POS]   = ~st.sec[OSC_POS];
            end
            default: begin
               next_st.err = 1'b1;
            end
         endcase
      end
      // Access cycle: writes take effect here
      if (access && pwrite_i && !st.err) begin
         case (sel)
            CPSB_SEL_TARGET: begin
               next_st.target = (st.target & ~wmask[16:0]) | (pwdata_i[16:0] & wmask[16:0]);
            end
            default: begin
            end
         endcase
      end
      // Programming only clears bits; erase sets them all
      if (prog_evt) begin
         next_st.sec = st.sec & pwdata_i[7:0];
      end
      if (erase_evt) begin
         next_st.sec = SEC_ERASED;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         st.prog_s1 <= 1'b0;
         st.prog_s2 <= 1'b0;
         st.target  <= TARGET_RST;
         st.sec     <= SEC_RST_VAL;
         st.rdata   <= 32'h00000000;
         st.err     <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // Bus answer
   // ****************************************
   assign pready_o  = 1'b1;
   assign prdata_o  = st.rdata;
   assign pslverr_o = access & st.err;

   // ****************************************
   // Protection outputs
   // ****************************************
   assign ext_access_ok_o = prog_mode & lock_open;
   assign osc_gain_half_o = ~st.sec[OSC_POS];
   assign tbl_rd_ext_o    = tbl_rd_i & ~tbl_tgt_int_i;
   assign tbl_rd_int_o    = tbl_rd_i & tbl_tgt_int_i &
                            (~tbl_from_ext_i | st.sec[TRR_POS]);

   // ****************************************
   // Port 0 encoding
   // ****************************************
   assign sec_if.enc_on = ~st.sec[ENC_POS];
   assign sec_if.p0_raw = p0_data_i;
   assign p0_data_o     = sec_if.p0_enc;

   cpsb_p0_encoder #(
      .ENC_KEY (ENC_KEY)
   ) u_p0_enc (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .sec_if    (sec_if)
   );

   // ****************************************
   // Checks
   // ****************************************
   sequence data_setup_s;
      setup && (sel == CPSB_SEL_DATA);
   endsequence
   sequence data_access_s;
      access && (sel == CPSB_SEL_DATA);
   endsequence

   sequence cmd_setup_s;
      setup && (sel == CPSB_SEL_COMMAND);
   endsequence
   sequence cmd_access_s;
      access && (sel == CPSB_SEL_COMMAND);
   endsequence

   prog_only_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (data_setup_s and (!prog_mode && $stable(prog_mode_i))) ##1 data_access_s |-> pslverr_o)
      else $error("security access outside programming mode not refused");
   sec_clear_only_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !erase_evt |=> (st.sec & ~$past(st.sec)) == 8'h00)
      else $error("security bit raised without erase");
   erase_all_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      erase_evt |=> st.sec == SEC_ERASED)
      else $error("erase did not set all security bits");
   sec_loc_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      data_setup_s ##1 (data_access_s and !pslverr_o) |-> $past(at_sec_loc))
      else $error("security data served away from its location");
   lock_refuse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (data_setup_s and !lock_open) ##1 data_access_s |-> pslverr_o && prdata_o == 32'h00000000
      ##1 st.sec == $past(st.sec, 2))
      else $error("locked security register was reachable");
   lock_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !lock_open |-> !ext_access_ok_o)
      else $error("flash access open while locked");
   tbl_ext_only_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (tbl_rd_i && tbl_from_ext_i && !st.sec[TRR_POS]) |-> !tbl_rd_int_o)
      else $error("external table read reached internal flash");
   tbl_int_free_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (tbl_rd_i && !tbl_from_ext_i) |-> (tbl_rd_int_o || tbl_rd_ext_o))
      else $error("internal table read was blocked");
   tbl_open_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (tbl_rd_i && st.sec[TRR_POS] && tbl_tgt_int_i) |-> tbl_rd_int_o)
      else $error("table read restricted with restrict bit at one");
   enc_sticky_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (sec_if.enc_on && !erase_evt) |=> sec_if.enc_on)
      else $error("encryption disabled without erase");
   osc_half_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (prog_evt && !pwdata_i[OSC_POS]) |=> osc_gain_half_o [*2])
      else $error("oscillator gain not halved after bit seven cleared");
   erased_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      erase_evt |=> !osc_gain_half_o && !sec_if.enc_on && lock_open && st.sec[TRR_POS])
      else $error("protection active after erase");
   prog_sync_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      ($past(rst_b_i) && $past(rst_b_i, 2)) |-> prog_mode == $past(prog_mode_i, 2))
      else $error("programming mode not taken through two flip-flops");
   cmd_refuse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (cmd_setup_s and !prog_mode) ##1 cmd_access_s |-> pslverr_o)
      else $error("erase command outside programming mode not refused");
   refused_noop_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (access && pslverr_o) |=> $stable(st.sec))
      else $error("refused transfer changed the security register");
   refuse_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (setup && !pwrite_i) ##1 (access && pslverr_o) |-> prdata_o == 32'h00000000)
      else $error("refused read returned data");
   prog_and_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      prog_evt |=> st.sec == ($past(st.sec) & $past(pwdata_i[7:0])))
      else $error("programming did not clear exactly the written zero bits");
   lock_sticky_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (!lock_open && !erase_evt) |=> !lock_open)
      else $error("lock bit released without erase");
   trr_sticky_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (!st.sec[TRR_POS] && !erase_evt) |=> !st.sec[TRR_POS])
      else $error("restrict bit released without erase");
   tbl_ext_reach_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (tbl_rd_i && !tbl_tgt_int_i) |-> tbl_rd_ext_o)
      else $error("table read to external memory blocked");
   tbl_int_reach_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (tbl_rd_i && !tbl_from_ext_i && tbl_tgt_int_i) |-> tbl_rd_int_o)
      else $error("internal code table read kept from internal flash");
   tbl_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !tbl_rd_i |-> (!tbl_rd_int_o && !tbl_rd_ext_o))
      else $error("table read route active without request");
   osc_steady_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (!prog_evt && !erase_evt) |=> $stable(osc_gain_half_o))
      else $error("oscillator gain changed without programming or erase");
endmodule

/* File: rtl/cpsb_pkg.sv */
/*
 * Constants shared by the code-protection security-bit block: APB register
 * offsets, field positions, reset values and the register selector type.
 * Assumes a 32-bit APB with byte addresses and word-aligned registers.
 */
package cpsb_pkg;
   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam int unsigned APB_AW       = 8;
   localparam logic [7:0]  OFS_TARGET   = 8'h00;
   localparam logic [7:0]  OFS_DATA     = 8'h04;
   localparam logic [7:0]  OFS_COMMAND  = 8'h08;
   localparam logic [7:0]  OFS_STATUS   = 8'h0C;
   // ****************************************
   // Security register fields
   // ****************************************
   localparam int unsigned LOCK_POS     = 0;
   localparam int unsigned TRR_POS      = 1;
   localparam int unsigned ENC_POS      = 2;
   localparam int unsigned OSC_POS      = 7;
   localparam logic [7:0]  SEC_ERASED   = 8'hFF;
   localparam logic [7:0]  SEC_RST_VAL  = 8'hFF;
   // ****************************************
   // Target register fields
   // ****************************************
   localparam int unsigned BANK_POS     = 16;
   localparam logic        BANK_LOADER  = 1'b1;
   localparam logic [15:0] SEC_LOC_ADDR = 16'hFFFF;
   localparam logic [16:0] TARGET_RST   = 17'h00000;
   // ****************************************
   // Command and status fields
   // ****************************************
   localparam int unsigned CMD_ERASE_POS  = 0;
   localparam int unsigned STAT_PROG_POS  = 0;
   localparam int unsigned STAT_EXTOK_POS = 1;
   localparam int unsigned STAT_TRR_POS   = 2;
   localparam int unsigned STAT_ENC_POS   = 3;
   localparam int unsigned STAT_OSC_POS   = 4;
   localparam logic [7:0]  P0_RST_VAL     = 8'h00;
   // Register selector decoded from the bus address
   typedef enum logic [2:0] {
      CPSB_SEL_NONE,
      CPSB_SEL_TARGET,
      CPSB_SEL_DATA,
      CPSB_SEL_COMMAND,
      CPSB_SEL_STATUS
   } cpsb_sel_t;
endpackage

/* File: rtl/cpsb_sec_if.sv */
/*
 * Carrier between the security-bit core and the port 0 encoder.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface cpsb_sec_if;
   logic       enc_on;
   logic [7:0] p0_raw;
   logic [7:0] p0_enc;
   modport core (output enc_on, output p0_raw, input p0_enc);
   modport enc  (input enc_on, input p0_raw, output p0_enc);
endinterface

/* File: rtl/cpsb_p0_encoder.sv */
/*
 * Port 0 output stage: registers the bus value, encoded when enabled.
 * Assumes raw data comes from logic on the same clock.
 */
`timescale 1ns/1ps
module cpsb_p0_encoder
   import cpsb_pkg::*;
#(
   parameter logic [7:0] ENC_KEY = 8'h5A    // Arbitrary scrambling key
) (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   // Core side
   cpsb_sec_if.enc   sec_if
);
   typedef struct packed {
      logic [7:0] p0;
   } cpsb_enc_state_t;

   cpsb_enc_state_t st;
   cpsb_enc_state_t next_st;

   function automatic logic [7:0] cpsb_encode(input logic [7:0] d);
      logic [7:0] x;
      x = d ^ ENC_KEY;
      return {x[6:0], x[7]};
   endfunction

   // ****************************************
   // Encoding stage
   // ****************************************
   always_comb begin
      next_st = st;
      if (sec_if.enc_on) begin
         next_st.p0 = cpsb_encode(sec_if.p0_raw);
      end else begin
         next_st.p0 = sec_if.p0_raw;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         st.p0 <= P0_RST_VAL;
      end else begin
         st <= next_st;
      end
   end

   assign sec_if.p0_enc = st.p0;

   // ****************************************
   // Checks
   // ****************************************
   enc_applied_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      sec_if.enc_on |=> sec_if.p0_enc == {$past(sec_if.p0_raw[6:0]) ^ ENC_KEY[6:0],
                                         $past(sec_if.p0_raw[7]) ^ ENC_KEY[7]})
      else $error("port 0 value not encoded");
   enc_bypass_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !sec_if.enc_on |=> sec_if.p0_enc == $past(sec_if.p0_raw))
      else $error("port 0 value altered while encoding off");
endmodule

/* File: tb/cpsb_prog_model.sv */
/*
 * Model of the external device programmer: an APB master and the
 * programming-mode pin. Assumes a single clock shared with the block.
 */
`timescale 1ns/1ps
module cpsb_prog_model
   import cpsb_pkg::*;
(
   // Clock
   input  wire logic              sys_clk_i,
   // APB master
   output      logic              psel_o,
   output      logic              penable_o,
   output      logic              pwrite_o,
   output      logic [APB_AW-1:0] paddr_o,
   output      logic [31:0]       pwdata_o,
   output      logic [3:0]        pstrb_o,
   input  wire logic [31:0]       prdata_i,
   input  wire logic              pready_i,
   input  wire logic              pslverr_i,
   // Programming mode pin
   output      logic              prog_mode_o
);
   logic [31:0] rd_data;
   logic        rd_err;

   initial begin
      psel_o      = 1'b0;
      penable_o   = 1'b0;
      pwrite_o    = 1'b0;
      paddr_o     = 8'h00;
      pwdata_o    = 32'h00000000;
      pstrb_o     = 4'h0;
      prog_mode_o = 1'b0;
      rd_data     = 32'h00000000;
      rd_err      = 1'b0;
   end

   // One transfer; request held until pready is seen high at an edge
   task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] strb);
      @(posedge sys_clk_i);
      psel_o    <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o  <= wr;
      paddr_o   <= adr;
      pwdata_o  <= wd;
      pstrb_o   <= strb;
      @(posedge sys_clk_i);
      penable_o <= 1'b1;
      do @(posedge sys_clk_i); while (pready_i !== 1'b1);
      rd_data = prdata_i;
      rd_err  = pslverr_i;
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      // Released address and data lines show no stale value
      paddr_o   <= ~adr;
      pwdata_o  <= ~wd;
   endtask

   // Pin change, then time for the two-stage synchroniser
   task automatic set_prog(input logic v);
      @(posedge sys_clk_i);
      prog_mode_o <= v;
      repeat (3) @(posedge sys_clk_i);
   endtask
endmodule

/* File: tb/tb.sv */
/*
 * Self-checking bench of the security-bit block driven through APB by
 * the programmer model. Assumes the package constants and ENC_KEY 8'h5A.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb;
   import cpsb_pkg::*;
   localparam logic [7:0] KEY = 8'h5A;
   logic              sys_clk_i = 1'b0;
   logic              rst_b_i = 1'b0;
   logic              psel, penable, pwrite, pready, pslverr, prog_mode;
   logic [APB_AW-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   logic [3:0]        pstrb;
   logic              tbl_rd = 1'b0, tbl_ext = 1'b0, tbl_int = 1'b0, gnt_int, gnt_ext;
   logic [7:0]        p0_in = 8'h00, p0_out;
   logic              ext_ok, osc_half;
   int                n_errors = 0, n_checks = 0, cyc = 0;

   always #12.5 sys_clk_i = ~sys_clk_i;

   cpsb_prog_model prog (.sys_clk_i(sys_clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
      .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb), .prdata_i(prdata), .pready_i(pready),
      .pslverr_i(pslverr), .prog_mode_o(prog_mode));

   cpsb_core #(.ENC_KEY(KEY)) dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .prog_mode_i(prog_mode),
      .tbl_rd_i(tbl_rd), .tbl_from_ext_i(tbl_ext), .tbl_tgt_int_i(tbl_int), .tbl_rd_int_o(gnt_int),
      .tbl_rd_ext_o(gnt_ext), .p0_data_i(p0_in), .p0_data_o(p0_out), .ext_access_ok_o(ext_ok),
      .osc_gain_half_o(osc_half));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic wr(input logic [7:0] adr, input logic [31:0] wd, input logic err);
      prog.xfer(1'b1, adr, wd, 4'hF);
      `CHK("write error", err, prog.rd_err)
   endtask

   task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic err);
      prog.xfer(1'b0, adr, 32'h00000000, 4'h0);
      `CHK("read error", err, prog.rd_err)
      `CHK("read data", exp, prog.rd_data)
   endtask

   // Port 0 value one edge after it is applied
   task automatic p0_chk(input logic [7:0] v, input logic enc);
      logic [7:0] x;
      logic [7:0] e;
      x = v ^ KEY;
      e = enc ? {x[6:0], x[7]} : v;
      @(posedge sys_clk_i);
      p0_in <= v;
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      `CHK("port0", e, p0_out)
   endtask

   // All table-read request combinations against the route equations
   task automatic tbl_sweep(input logic restr);
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk_i);
         {tbl_rd, tbl_ext, tbl_int} <= i[2:0];
         @(negedge sys_clk_i);
         `CHK("tbl int", i[2] & i[0] & (~i[1] | ~restr), gnt_int)
         `CHK("tbl ext", i[2] & ~i[0], gnt_ext)
      end
   endtask

   initial begin
      repeat (16) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      @(negedge sys_clk_i);
      `CHK("osc reset", 1'b0, osc_half)
      `CHK("ext ok reset", 1'b0, ext_ok)
      rd(OFS_DATA, 32'h00000000, 1'b1);
      wr(OFS_COMMAND, 32'h00000001, 1'b1);
      rd(OFS_STATUS, 32'h00000000, 1'b0);
      p0_chk(8'h3C, 1'b0);
      $display("test outside programming mode done");

      prog.set_prog(1'b1);
      rd(OFS_STATUS, 32'h00000003, 1'b0);
      wr(OFS_TARGET, 32'h0000FFFF, 1'b0);
      rd(OFS_DATA, 32'h00000000, 1'b1);
      wr(OFS_TARGET, 32'h0001FFFE, 1'b0);
      rd(OFS_DATA, 32'h00000000, 1'b1);
      wr(OFS_TARGET, 32'h0001FFFF, 1'b0);
      rd(OFS_TARGET, 32'h0001FFFF, 1'b0);
      prog.xfer(1'b1, OFS_TARGET, 32'h00000000, 4'h3);
      rd(OFS_TARGET, 32'h00010000, 1'b0);
      wr(OFS_TARGET, 32'h0001FFFF, 1'b0);
      rd(OFS_DATA, 32'h000000FF, 1'b0);
      wr(8'h10, 32'h00000000, 1'b1);
      wr(OFS_STATUS, 32'h00000000, 1'b1);
      $display("test security location done");

      prog.xfer(1'b1, OFS_DATA, 32'h00000000, 4'hE);
      rd(OFS_DATA, 32'h000000FF, 1'b0);
      tbl_sweep(1'b0);
      wr(OFS_DATA, 32'h000000FB, 1'b0);
      wr(OFS_DATA, 32'h000000FF, 1'b0);
      rd(OFS_DATA, 32'h000000FB, 1'b0);
      p0_chk(8'h3C, 1'b1);
      p0_chk(8'hA5, 1'b1);
      wr(OFS_DATA, 32'h000000F9, 1'b0);
      tbl_sweep(1'b1);
      wr(OFS_DATA, 32'h0000007F, 1'b0);
      @(negedge sys_clk_i);
      `CHK("osc half", 1'b1, osc_half)
      rd(OFS_STATUS, 32'h0000001F, 1'b0);
      $display("test one-way programming done");

      wr(OFS_DATA, 32'h000000FE, 1'b0);
      rd(OFS_DATA, 32'h00000000, 1'b1);
      wr(OFS_DATA, 32'h00000000, 1'b1);
      `CHK("ext ok locked", 1'b0, ext_ok)
      rd(OFS_STATUS, 32'h0000001D, 1'b0);
      $display("test lock done");

      wr(OFS_COMMAND, 32'h00000001, 1'b0);
      rd(OFS_DATA, 32'h000000FF, 1'b0);
      `CHK("osc erased", 1'b0, osc_half)
      rd(OFS_STATUS, 32'h00000003, 1'b0);
      p0_chk(8'h3C, 1'b0);
      tbl_sweep(1'b0);
      prog.set_prog(1'b0);
      rd(OFS_DATA, 32'h00000000, 1'b1);
      $display("test erase done");
      print_verdict();
   end
endmodule
